// *** logic/cpr_port.sv ***
// Serial two-wire slave port of the charger: status read, configuration write.
// Assumes the bus master drives the clock line and that both bus lines are
// pulled up outside; the data line is open drain and only ever pulled low.
`timescale 1ns/10ps
`default_nettype none

module cpr_port (
    input wire logic i_clk_sys,                       // system clock, 250 MHz
    input wire logic i_rst,                           // async reset, active high
    input wire logic i_ce,                            // clock enable, freezes state
    input wire logic i_scl,                           // bus clock from master
    input wire logic i_sda,                           // bus data line level
    output logic o_sda_o,                             // data drive value, always low
    output logic o_sda_oe,                            // high while pulling data low
    input wire logic i_undervoltage_lockout,          // supply below lockout
    input wire logic i_device_reset_active,           // device reset asserted
    input wire logic i_battery_too_warm,              // battery above hot limit
    input wire logic i_battery_too_cool,              // battery below cold limit
    input wire logic i_input_overvoltage_flag,        // input above 6.6 V
    input wire logic i_charging_in_progress,          // charger charging
    input wire logic i_input_power_valid,             // input power valid
    input wire logic i_thermal_regulation_active,     // thermal loop active
    output logic [1:0] o_power_path_voltage_select,   // power-path output select
    output logic [1:0] o_input_limit_select,          // input current limit select
    output logic o_thermal_regulation_enable,         // thermal loop enable
    output logic o_adaptive_safety_clock,             // dynamic safety timer
    output logic o_termination_enable,                // charge termination enable
    output logic o_charger_on,                        // charger enable
    output logic o_busy                               // addressed transfer ongoing
);

    typedef struct packed {
        cpr_pkg::cpr_state_e state;
        cpr_pkg::cpr_state_e ack_next;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic [7:0] cfg;
        logic [7:0] stat;
        logic mack;
        logic scl_p;
        logic sda_p;
        logic sda_oe;
        logic sda_o;
        logic busy;
    } cpr_regs_s;

    cpr_regs_s q;
    cpr_regs_s d;

    logic [cpr_pkg::SYNC_WIDTH-1:0] raw;
    logic [cpr_pkg::SYNC_WIDTH-1:0] syn;
    logic scl_s;
    logic sda_s;
    logic lock_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic [7:0] rd_byte;

    // Both bus pins, the lockout levels and the analog status flags are asynchronous.
    assign raw = {i_scl, i_sda, i_undervoltage_lockout, i_device_reset_active,
                  i_battery_too_warm, i_battery_too_cool, i_input_overvoltage_flag,
                  i_charging_in_progress, i_input_power_valid,
                  i_thermal_regulation_active};

    cpr_sync #(
        .WIDTH(cpr_pkg::SYNC_WIDTH)
    ) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_async(raw),
        .o_sync(syn)
    );

    assign scl_s = syn[9];
    assign sda_s = syn[8];
    assign lock_s = syn[7] | syn[6];

    // The bus runs at 400 kHz at most, so the 4 ns clock sees many samples
    // per phase and plain edge detection on the synchronised lines suffices.
    assign scl_rise = scl_s & ~q.scl_p;
    assign scl_fall = ~scl_s & q.scl_p;

    // A data change while the clock stays high is only ever start or stop.
    assign start_det = q.scl_p & scl_s & q.sda_p & ~sda_s;
    assign stop_det = q.scl_p & scl_s & ~q.sda_p & sda_s;

    // Read mux over the register map.
    always_comb begin
        unique case (q.ptr)
            cpr_pkg::ADDR_CHARGER_STATUS: rd_byte = q.stat;
            cpr_pkg::ADDR_CHARGER_CONFIG_ZERO: rd_byte = q.cfg;
            default: rd_byte = cpr_pkg::READ_UNMAPPED;
        endcase
    end

    always_comb begin
        d = q;
        d.scl_p = scl_s;
        d.sda_p = sda_s;
        d.sda_o = 1'b0;

        // Status is sampled every cycle; unused bits 4 and 0 read zero.
        d.stat = {syn[5], syn[4], syn[3], 1'b0, syn[2], syn[1], syn[0], 1'b0};

        if (start_det) begin
            // Also covers a repeated start in the middle of a transfer.
            d.state = cpr_pkg::ST_ADDR;
            d.cnt = 4'h0;
            d.sda_oe = 1'b0;
            d.busy = 1'b0;
        end else if (stop_det) begin
            d.state = cpr_pkg::ST_IDLE;
            d.sda_oe = 1'b0;
            d.busy = 1'b0;
        end else begin
            unique case (q.state)
                cpr_pkg::ST_IDLE: begin
                    d.sda_oe = 1'b0;
                end

                cpr_pkg::ST_ADDR, cpr_pkg::ST_REG, cpr_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        // One bit per clock pulse, sampled while the clock is high.
                        d.sh = {q.sh[6:0], sda_s};
                        d.cnt = q.cnt + 4'h1;
                    end else if (scl_fall && q.cnt == cpr_pkg::BITS_PER_BYTE) begin
                        d.cnt = 4'h0;
                        d.state = cpr_pkg::ST_ACK;
                        d.sda_oe = 1'b1;
                        unique case (q.state)
                            cpr_pkg::ST_ADDR: begin
                                if (q.sh[7:1] == cpr_pkg::SLAVE_ADDR) begin
                                    d.busy = 1'b1;
                                    d.ack_next = q.sh[0] ? cpr_pkg::ST_RDATA
                                                         : cpr_pkg::ST_REG;
                                end else begin
                                    // Foreign address: stay silent until the next start.
                                    d.state = cpr_pkg::ST_IDLE;
                                    d.sda_oe = 1'b0;
                                end
                            end
                            cpr_pkg::ST_REG: begin
                                d.ptr = q.sh;
                                d.ack_next = cpr_pkg::ST_WDATA;
                            end
                            default: begin
                                // Only the configuration register takes writes.
                                if (q.ptr == cpr_pkg::ADDR_CHARGER_CONFIG_ZERO) begin
                                    d.cfg = q.sh;
                                end
                                d.ptr = q.ptr + 8'h01;
                                d.ack_next = cpr_pkg::ST_WDATA;
                            end
                        endcase
                    end
                end

                cpr_pkg::ST_ACK: begin
                    // The master's ninth clock pulse carries the acknowledge.
                    if (scl_fall) begin
                        d.sda_oe = 1'b0;
                        d.cnt = 4'h0;
                        d.state = q.ack_next;
                        if (q.ack_next == cpr_pkg::ST_RDATA) begin
                            d.sda_oe = ~rd_byte[7];
                            d.sh = {rd_byte[6:0], 1'b0};
                            d.ptr = q.ptr + 8'h01;
                        end
                    end
                end

                cpr_pkg::ST_RDATA: begin
                    if (scl_rise) begin
                        d.cnt = q.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (q.cnt == cpr_pkg::BITS_PER_BYTE) begin
                            // Let go so the master can drive its acknowledge.
                            d.sda_oe = 1'b0;
                            d.state = cpr_pkg::ST_MACK;
                        end else begin
                            // Data only changes on the falling clock edge.
                            d.sda_oe = ~q.sh[7];
                            d.sh = {q.sh[6:0], 1'b0};
                        end
                    end
                end

                cpr_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        d.mack = ~sda_s;
                    end else if (scl_fall) begin
                        d.cnt = 4'h0;
                        if (q.mack) begin
                            d.state = cpr_pkg::ST_RDATA;
                            d.sda_oe = ~rd_byte[7];
                            d.sh = {rd_byte[6:0], 1'b0};
                            d.ptr = q.ptr + 8'h01;
                        end else begin
                            // Last byte: keep the line released until stop.
                            d.state = cpr_pkg::ST_IDLE;
                            d.sda_oe = 1'b0;
                        end
                    end
                end

                default: begin
                    d.state = cpr_pkg::ST_IDLE;
                    d.sda_oe = 1'b0;
                end
            endcase
        end

        // Lockout overrides a write landing in the same cycle.
        if (lock_s) begin
            d.cfg = cpr_pkg::CONFIG_ZERO_RESET;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            q.state <= cpr_pkg::ST_IDLE;
            q.ack_next <= cpr_pkg::ST_IDLE;
            q.cnt <= 4'h0;
            q.sh <= 8'h00;
            q.ptr <= 8'h00;
            q.cfg <= cpr_pkg::CONFIG_ZERO_RESET;
            q.stat <= 8'h00;
            q.mack <= 1'b0;
            q.scl_p <= 1'b0;
            q.sda_p <= 1'b0;
            q.sda_oe <= 1'b0;
            q.sda_o <= 1'b0;
            q.busy <= 1'b0;
        end else if (i_ce) begin
            q <= d;
        end
    end

    assign o_sda_o = q.sda_o;
    assign o_sda_oe = q.sda_oe;
    assign o_busy = q.busy;

    // Configuration fields straight from the stored register.
    assign o_power_path_voltage_select = q.cfg[cpr_pkg::CFG_VSEL_HI:cpr_pkg::CFG_VSEL_LO];
    assign o_input_limit_select = q.cfg[cpr_pkg::CFG_ILIM_HI:cpr_pkg::CFG_ILIM_LO];
    assign o_thermal_regulation_enable = q.cfg[cpr_pkg::CFG_THERM_EN];
    assign o_adaptive_safety_clock = q.cfg[cpr_pkg::CFG_ADAPT];
    assign o_termination_enable = q.cfg[cpr_pkg::CFG_TERM_EN];
    assign o_charger_on = q.cfg[cpr_pkg::CFG_CHG_ON];

endmodule

`default_nettype wire

// *** inc/cpr_pkg.sv ***
// Shared constants and types for the charger register port.
// Assumes a single system clock domain; the bus pins are asynchronous to it.
package cpr_pkg;

    // Slave address, fixed for this device variant.
    localparam logic [6:0] SLAVE_ADDR = 7'h48;

    // Register map.
    localparam logic [7:0] ADDR_CHARGER_STATUS = 8'h01;
    localparam logic [7:0] ADDR_CHARGER_CONFIG_ZERO = 8'h02;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Value of the configuration register after reset or lockout.
    localparam logic [7:0] CONFIG_ZERO_RESET = 8'h6F;

    // Field positions of the configuration register.
    localparam int CFG_VSEL_HI = 7;
    localparam int CFG_VSEL_LO = 6;
    localparam int CFG_ILIM_HI = 5;
    localparam int CFG_ILIM_LO = 4;
    localparam int CFG_THERM_EN = 3;
    localparam int CFG_ADAPT = 2;
    localparam int CFG_TERM_EN = 1;
    localparam int CFG_CHG_ON = 0;

    // Bus timing.
    localparam int BUS_FMAX_KHZ = 400;
    localparam int CLK_SYS_MHZ = 250;
    localparam int SCL_HIGH_MIN_NS = 600;
    localparam int SCL_HIGH_MIN_CYC = (SCL_HIGH_MIN_NS * CLK_SYS_MHZ + 999) / 1000;

    // Bits per byte and count of synchronised inputs.
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int SYNC_WIDTH = 10;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_REG,
        ST_WDATA,
        ST_ACK,
        ST_RDATA,
        ST_MACK
    } cpr_state_e;

endpackage

// *** logic/cpr_sync.sv ***
// Two-stage synchroniser for a group of asynchronous levels.
// Assumes the inputs are quasi-static compared with the system clock.
`timescale 1ns/10ps
`default_nettype none

module cpr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk_sys,              // system clock
    input wire logic i_rst,                  // async reset, active high
    input wire logic i_ce,                   // clock enable
    input wire logic [WIDTH-1:0] i_async,    // levels from outside
    output logic [WIDTH-1:0] o_sync          // synchronised levels
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // Only the second stage is ever read by other logic.
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge i_clk_sys or posedge i_rst) begin
                if (i_rst) begin
                    meta_q[g] <= 1'b0;
                    sync_q[g] <= 1'b0;
                end else if (i_ce) begin
                    meta_q[g] <= i_async[g];
                    sync_q[g] <= meta_q[g];
                end
            end
        end
    endgenerate

    assign o_sync = sync_q;

endmodule

`default_nettype wire

// *** verif/cpr_port_properties.sv ***
// Concurrent checks on the ports of the charger register port.
// Assumes one clock domain and a bus that idles high between frames.
`timescale 1ns/10ps
`default_nettype none
module cpr_port_properties (
    input wire logic i_clk_sys, // clock
    input wire logic i_rst, // reset
    input wire logic i_scl, // bus clock
    input wire logic o_sda_o, // drive value
    input wire logic o_sda_oe, // drive enable
    input wire logic i_undervoltage_lockout, // lockout
    input wire logic i_device_reset_active, // device reset
    input wire logic [1:0] o_power_path_voltage_select, // cfg 7..6
    input wire logic [1:0] o_input_limit_select, // cfg 5..4
    input wire logic o_thermal_regulation_enable, // cfg 3
    input wire logic o_adaptive_safety_clock, // cfg 2
    input wire logic o_termination_enable, // cfg 1
    input wire logic o_charger_on, // cfg 0
    input wire logic o_busy // transfer open
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    logic [7:0] cfg;
    logic [2:0] lk_q;
    logic [7:0] oe_cnt_q;
    assign cfg = {o_power_path_voltage_select, o_input_limit_select,
        o_thermal_regulation_enable, o_adaptive_safety_clock,
        o_termination_enable, o_charger_on};
    // A lockout takes two sync stages and a load to show, so recent ones are remembered.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            lk_q <= 3'h0;
            oe_cnt_q <= 8'h00;
        end else begin
            lk_q <= {lk_q[1:0], i_undervoltage_lockout | i_device_reset_active};
            oe_cnt_q <= o_sda_oe ? oe_cnt_q + 8'h01 : 8'h00;
        end
    end
    sequence s_lockout_held;
        i_undervoltage_lockout [*5];
    endsequence
    sequence s_dev_reset_held;
        i_device_reset_active [*5];
    endsequence
    sequence s_drive_at_rise;
        $rose(i_scl) && o_sda_oe;
    endsequence
    chk_drive_value_low: assert property (o_sda_o == 1'b0)
        else $error("data drive value not low");
    chk_lockout_default: assert property (s_lockout_held |-> cfg == 8'h6F)
        else $error("lockout did not load default");
    chk_devreset_default: assert property (s_dev_reset_held |-> cfg == 8'h6F)
        else $error("device reset did not load default");
    chk_reset_gives_default: assert property ($fell(i_rst) |-> cfg == 8'h6F)
        else $error("config not default after reset");
    chk_sda_moves_low: assert property ($changed(o_sda_oe) |-> !i_scl)
        else $error("data drive changed while clock high");
    chk_ack_stable_high: assert property (s_drive_at_rise |-> o_sda_oe [*8])
        else $error("data drive dropped during clock high");
    chk_cfg_idle_quiet: assert property (!o_busy && lk_q == 3'h0 &&
        !(i_undervoltage_lockout | i_device_reset_active) |=> $stable(cfg))
        else $error("config changed outside a transfer");
    chk_drive_released: assert property (oe_cnt_q < 8'hA0)
        else $error("data line held low too long");
endmodule
`default_nettype wire

// *** verif/cpr_host_model.sv ***
// Bus master model: drives the clock and pulls the data wire low.
// Assumes the bench resolves the open-drain wire and feeds it back.
`timescale 1ns/10ps
`default_nettype none
module cpr_host_model (
    input wire logic i_clk_sys, // pacing clock
    input wire logic i_sda, // resolved data wire
    output logic o_scl, // bus clock
    output logic o_sda_oe // high while pulling low
);
    // The bus clock stands high between frames; one bit is 16 clocks, 64 ns.
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic bit_io(input logic b, output logic r);
        tick(4);
        o_sda_oe = !b;
        tick(4);
        o_scl = 1'b1;
        tick(4);
        r = i_sda;
        tick(4);
        o_scl = 1'b0;
    endtask
    task automatic start_cond();
        tick(4);
        o_sda_oe = 1'b0;
        tick(4);
        o_scl = 1'b1;
        tick(4);
        o_sda_oe = 1'b1;
        tick(4);
        o_scl = 1'b0;
    endtask
    task automatic stop_cond();
        tick(4);
        o_sda_oe = 1'b1;
        tick(4);
        o_scl = 1'b1;
        tick(4);
        o_sda_oe = 1'b0;
        tick(4);
    endtask
    task automatic byte_tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic byte_rx(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(last, r);
    endtask
    task automatic write_reg(input logic [6:0] sa, input logic [7:0] ra,
        input logic [7:0] d, output logic [2:0] ak);
        start_cond();
        byte_tx({sa, 1'b0}, ak[2]);
        byte_tx(ra, ak[1]);
        byte_tx(d, ak[0]);
        stop_cond();
    endtask
    task automatic read_reg(input logic [6:0] sa, input logic [7:0] ra,
        output logic [7:0] d, output logic [2:0] ak);
        start_cond();
        byte_tx({sa, 1'b0}, ak[2]);
        byte_tx(ra, ak[1]);
        start_cond();
        byte_tx({sa, 1'b1}, ak[0]);
        byte_rx(1'b1, d);
        stop_cond();
    endtask
    // Two bytes in one read: the first is acknowledged, so the port must go on.
    task automatic read_pair(input logic [6:0] sa, input logic [7:0] ra,
        output logic [15:0] d, output logic [2:0] ak);
        start_cond();
        byte_tx({sa, 1'b0}, ak[2]);
        byte_tx(ra, ak[1]);
        start_cond();
        byte_tx({sa, 1'b1}, ak[0]);
        byte_rx(1'b0, d[15:8]);
        byte_rx(1'b1, d[7:0]);
        stop_cond();
    endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Bench for the charger register port: register writes and reads over the bus.
// Assumes the host model paces all bus traffic from the system clock.
`timescale 1ns/10ps
`default_nettype none
bind cpr_port cpr_port_properties u_props (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_scl(i_scl), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
    .i_undervoltage_lockout(i_undervoltage_lockout),
    .i_device_reset_active(i_device_reset_active),
    .o_power_path_voltage_select(o_power_path_voltage_select),
    .o_input_limit_select(o_input_limit_select),
    .o_thermal_regulation_enable(o_thermal_regulation_enable),
    .o_adaptive_safety_clock(o_adaptive_safety_clock),
    .o_termination_enable(o_termination_enable), .o_charger_on(o_charger_on),
    .o_busy(o_busy));
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic lockout = 1'b0;
    logic dres = 1'b0;
    logic [5:0] st = 6'h00;
    logic dev_oe, host_oe, scl;
    wire sda;
    wire [7:0] cfg;
    int failures = 0;
    int cmp_count = 0;
    logic [7:0] pats [4] = '{8'h00, 8'h55, 8'hAA, 8'hFF};
    logic [5:0] stp [3] = '{6'h3F, 6'h2A, 6'h15};
    always #2 clk = ~clk;
    assign sda = !(dev_oe | host_oe);
    cpr_port u_cpr_port (.i_clk_sys(clk), .i_rst(rst), .i_ce(1'b1), .i_scl(scl),
        .i_sda(sda), .o_sda_o(), .o_sda_oe(dev_oe), .i_undervoltage_lockout(lockout),
        .i_device_reset_active(dres), .i_battery_too_warm(st[5]),
        .i_battery_too_cool(st[4]), .i_input_overvoltage_flag(st[3]),
        .i_charging_in_progress(st[2]), .i_input_power_valid(st[1]),
        .i_thermal_regulation_active(st[0]), .o_power_path_voltage_select(cfg[7:6]),
        .o_input_limit_select(cfg[5:4]), .o_thermal_regulation_enable(cfg[3]),
        .o_adaptive_safety_clock(cfg[2]), .o_termination_enable(cfg[1]),
        .o_charger_on(cfg[0]), .o_busy());
    cpr_host_model u_host (.i_clk_sys(clk), .i_sda(sda), .o_scl(scl),
        .o_sda_oe(host_oe));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        if (failures == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [6:0] sa, input logic [7:0] ra, input logic [7:0] d,
        input logic [2:0] ea);
        logic [2:0] ak;
        u_host.write_reg(sa, ra, d, ak);
        check("write acks", {5'h00, ak}, {5'h00, ea});
    endtask
    task automatic rd(input logic [7:0] ra, input logic [7:0] exp);
        logic [2:0] ak;
        logic [7:0] d;
        u_host.read_reg(7'h48, ra, d, ak);
        check("read acks", {5'h00, ak}, 8'h07);
        check("read data", d, exp);
    endtask
    task automatic rd2(input logic [7:0] ra, input logic [15:0] exp);
        logic [2:0] ak;
        logic [15:0] d;
        u_host.read_pair(7'h48, ra, d, ak);
        check("pair acks", {5'h00, ak}, 8'h07);
        check("first of pair", d[15:8], exp[15:8]);
        check("second of pair", d[7:0], exp[7:0]);
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        end_of_test();
    end
    initial begin
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        check("cfg after reset", cfg, 8'h6F);
        rd(8'h02, 8'h6F);
        foreach (pats[i]) begin
            wr(7'h48, 8'h02, pats[i], 3'h7);
            check("cfg pins", cfg, pats[i]);
            rd(8'h02, pats[i]);
        end
        wr(7'h48, 8'h01, 8'h00, 3'h7);
        wr(7'h48, 8'h09, 8'h00, 3'h7);
        wr(7'h49, 8'h02, 8'h00, 3'h0);
        check("cfg kept", cfg, 8'hFF);
        rd(8'h07, 8'h00);
        foreach (stp[i]) begin
            st = stp[i];
            rd(8'h01, {st[5:3], 1'b0, st[2:0], 1'b0});
        end
        // The pointer steps from status to configuration inside one read.
        rd2(8'h01, {st[5:3], 1'b0, st[2:0], 1'b0, 8'hFF});
        lockout = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        check("cfg in lockout", cfg, 8'h6F);
        lockout = 1'b0;
        wr(7'h48, 8'h02, 8'hFF, 3'h7);
        check("cfg after lockout", cfg, 8'hFF);
        dres = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        check("cfg in device reset", cfg, 8'h6F);
        dres = 1'b0;
        wr(7'h48, 8'h02, 8'h00, 3'h7);
        check("cfg before reset", cfg, 8'h00);
        // A second reset in mid-run must bring the default back.
        rst = 1'b1;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        check("cfg after second reset", cfg, 8'h6F);
        rd(8'h02, 8'h6F);
        end_of_test();
    end
endmodule
`default_nettype wire
